/* lsr_smbus_slave.sv */
`timescale 1ns/10ps
`default_nettype none

// ------------------------------------------------------------------
// Shared constants
// ------------------------------------------------------------------
package lsr_pkg;
	localparam int          CLK_HZ         = 200_000_000;
	localparam int          INTEG_TIME_MS  = 400;
	localparam int          INTEG_CYCLES   = (CLK_HZ / 1000) * INTEG_TIME_MS;
	localparam logic [7:0]  CMD_POWER_DOWN = 8'h00;
	localparam logic [7:0]  CMD_READ_CTRL  = 8'h03;
	localparam logic [7:0]  CMD_READ_CH0   = 8'h43;
	localparam logic [7:0]  CMD_READ_CH1   = 8'h83;
	localparam logic [7:0]  CMD_RESET      = 8'h00;
	localparam int          SEL_HI         = 7;
	localparam int          SEL_LO         = 6;
	localparam logic [1:0]  SEL_CTRL       = 2'h0;
	localparam logic [1:0]  SEL_CH0        = 2'h1;
	localparam logic [1:0]  SEL_CH1        = 2'h2;
	localparam int          ENABLE_BIT     = 1;
	localparam int          POWER_BIT      = 0;
	localparam int          VALID_BIT      = 7;
	// Arbitrary bus address; boards override it
	localparam logic [6:0]  DEV_ADDR       = 7'h2a;
	localparam logic [3:0]  BITS_PER_BYTE  = 4'h8;
	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_ADDR = 7'h02,
		ST_ACKA = 7'h04,
		ST_WR   = 7'h08,
		ST_ACKW = 7'h10,
		ST_RD   = 7'h20,
		ST_RACK = 7'h40
	} lsr_state_t;
endpackage : lsr_pkg

module lsr_smbus_slave #(
	parameter logic [6:0] DEV_ADDR = lsr_pkg::DEV_ADDR
) (
	input  wire logic       clk,
	input  wire logic       rst_b,
	input  wire logic       smbClkIn,
	input  wire logic       smbDataIn,
	output logic            smbDataOut,
	output logic            smbDataOe,
	input  wire logic [7:0] rdData,
	output logic            cmdStrobe,
	output logic [7:0]      cmdByte
);
	import lsr_pkg::*;

	// ------------------------------------------------------------------
	// Pin synchronisers and edge detection
	// ------------------------------------------------------------------
	logic       [1:0] sclSync;
	logic       [1:0] sdaSync;
	logic             sclPrev;
	logic             sdaPrev;
	lsr_state_t       state;
	logic       [3:0] bitCnt;
	logic       [7:0] shift;
	logic             isRead;

	wire sclS    = sclSync[1];
	wire sdaS    = sdaSync[1];
	wire sclRise = sclS & ~sclPrev;
	wire sclFall = ~sclS & sclPrev;
	wire startC  = sclS & sclPrev & sdaPrev & ~sdaS;
	wire stopC   = sclS & sclPrev & ~sdaPrev & sdaS;
	wire byteEnd = sclFall && (bitCnt == BITS_PER_BYTE);
	wire addrHit = (shift[7:1] == DEV_ADDR);

	// Open drain: only ever pulls low
	assign smbDataOut = 1'b0;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sclSync <= 2'h3;
			sdaSync <= 2'h3;
			sclPrev <= 1'b1;
			sdaPrev <= 1'b1;
		end else begin
			sclSync <= {sclSync[0], smbClkIn};
			sdaSync <= {sdaSync[0], smbDataIn};
			sclPrev <= sclS;
			sdaPrev <= sdaS;
		end
	end

	// ------------------------------------------------------------------
	// Byte engine: Send Byte and Receive Byte only
	// ------------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state     <= ST_IDLE;
			bitCnt    <= 4'h0;
			shift     <= 8'h00;
			isRead    <= 1'b0;
			smbDataOe <= 1'b0;
			cmdStrobe <= 1'b0;
			cmdByte   <= CMD_RESET;
		end else begin
			cmdStrobe <= 1'b0;
			if (startC) begin
				state     <= ST_ADDR;
				bitCnt    <= 4'h0;
				smbDataOe <= 1'b0;
			end else if (stopC) begin
				state     <= ST_IDLE;
				smbDataOe <= 1'b0;
			end else begin
				case (state)
				ST_ADDR, ST_WR: begin
					if (sclRise) begin
						shift  <= {shift[6:0], sdaS};
						bitCnt <= bitCnt + 4'h1;
					end else if (byteEnd && state == ST_ADDR) begin
						isRead    <= shift[0];
						smbDataOe <= addrHit;
						state     <= addrHit ? ST_ACKA : ST_IDLE;
					end else if (byteEnd) begin
						// Latest command byte picks the read source
						cmdByte   <= shift;
						cmdStrobe <= 1'b1;
						smbDataOe <= 1'b1;
						state     <= ST_ACKW;
					end
				end
				ST_ACKA: begin
					if (sclFall) begin
						bitCnt <= 4'h0;
						if (isRead) begin
							shift     <= rdData;
							smbDataOe <= ~rdData[7];
							state     <= ST_RD;
						end else begin
							smbDataOe <= 1'b0;
							state     <= ST_WR;
						end
					end
				end
				ST_RD: begin
					if (sclRise) begin
						bitCnt <= bitCnt + 4'h1;
					end else if (byteEnd) begin
						smbDataOe <= 1'b0;
						state     <= ST_RACK;
					end else if (sclFall) begin
						shift     <= {shift[6:0], 1'b0};
						smbDataOe <= ~shift[6];
					end
				end
				ST_ACKW, ST_RACK: begin
					// Extra bytes are ignored until the next start
					if (sclFall) begin
						smbDataOe <= 1'b0;
						state     <= ST_IDLE;
					end
				end
				default: begin
					state     <= ST_IDLE;
					smbDataOe <= 1'b0;
				end
				endcase
			end
		end
	end

	property p_cmd_ack;
		@(posedge clk) disable iff (!rst_b)
		cmdStrobe |-> smbDataOe && state == ST_ACKW;
	endproperty
	a_cmd_ack: assert property (p_cmd_ack)
		else $error("command byte not acknowledged");
endmodule : lsr_smbus_slave

`default_nettype wire

/* lsr_readout.sv */
// Contract
// - Repeated reads return the same held result, valid stays set.
// - A channel code changes only when its own conversion ends.
// - Channels convert alternately, 400 ms integration each.
// - Command register can be selected and read back.
// - Send Byte 0 clears converter enable and power on bits.
// - Commands 00h down, 03h control, 43h channel 0, 83h channel 1.
// - Receive Byte returns register chosen by latest command byte.
// - Result bit 7 set only after a conversion since enable.
`timescale 1ns/10ps
`default_nettype none

module lsr_readout #(
	parameter int         INTEG_CYCLES = lsr_pkg::INTEG_CYCLES,
	parameter logic [6:0] DEV_ADDR     = lsr_pkg::DEV_ADDR
) (
	input  wire logic       clk,
	input  wire logic       rst_b,
	input  wire logic       smbClkIn,
	input  wire logic       smbDataIn,
	output logic            smbDataOut,
	output logic            smbDataOe,
	input  wire logic [6:0] adcCode,
	output logic            convChannel,
	output logic            convDone,
	output logic            converterEnable,
	output logic            powerOn
);
	import lsr_pkg::*;

	localparam int CW = $clog2(INTEG_CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(INTEG_CYCLES - 1);

	// ------------------------------------------------------------------
	// Command register and read selection
	// ------------------------------------------------------------------
	logic          [7:0] cmdReg;
	logic          [7:0] result0;
	logic          [7:0] result1;
	logic          [7:0] rdData;
	logic                cmdStrobe;
	logic          [7:0] cmdByte;
	logic       [CW-1:0] integCnt;
	logic                curChan;

	lsr_smbus_slave #(
		.DEV_ADDR (DEV_ADDR)
	) u_slave (
		.clk        (clk),
		.rst_b      (rst_b),
		.smbClkIn   (smbClkIn),
		.smbDataIn  (smbDataIn),
		.smbDataOut (smbDataOut),
		.smbDataOe  (smbDataOe),
		.rdData     (rdData),
		.cmdStrobe  (cmdStrobe),
		.cmdByte    (cmdByte)
	);

	// Reset state is powered down, as after power-up
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			cmdReg <= CMD_RESET;
		else if (cmdStrobe)
			cmdReg <= cmdByte;
	end

	assign converterEnable = cmdReg[ENABLE_BIT];
	assign powerOn         = cmdReg[POWER_BIT];
	wire running = converterEnable & powerOn;
	wire [1:0] sel = cmdReg[SEL_HI:SEL_LO];

	// Unused select code falls back to the control register
	assign rdData = (sel == SEL_CH0) ? result0 :
			(sel == SEL_CH1) ? result1 :
			cmdReg;

	// ------------------------------------------------------------------
	// Alternating integration sequencer
	// ------------------------------------------------------------------
	wire doneNow = running && (integCnt == LAST);
	assign convDone    = doneNow;
	assign convChannel = curChan;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			integCnt <= '0;
			curChan  <= 1'b0;
		end else if (!running) begin
			integCnt <= '0;
			curChan  <= 1'b0;
		end else if (doneNow) begin
			integCnt <= '0;
			curChan  <= ~curChan;
		end else begin
			integCnt <= integCnt + CW'(1);
		end
	end

	// Codes keep their value across power down; only valid drops
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			result0 <= 8'h00;
			result1 <= 8'h00;
		end else if (!running) begin
			result0[VALID_BIT] <= 1'b0;
			result1[VALID_BIT] <= 1'b0;
		end else if (doneNow && !curChan) begin
			result0 <= {1'b1, adcCode};
		end else if (doneNow) begin
			result1 <= {1'b1, adcCode};
		end
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	property p_ctrl_readback;
		@(posedge clk) disable iff (!rst_b)
		cmdStrobe && cmdByte == CMD_READ_CTRL |=> rdData == CMD_READ_CTRL;
	endproperty
	a_ctrl_readback: assert property (p_ctrl_readback)
		else $error("control readback wrong");

	property p_power_down;
		@(posedge clk) disable iff (!rst_b)
		cmdStrobe && cmdByte == CMD_POWER_DOWN
			|=> !converterEnable && !powerOn
			##1 !result0[VALID_BIT] && !result1[VALID_BIT];
	endproperty
	a_power_down: assert property (p_power_down)
		else $error("power down did not clear enables");

	property p_sel_ch1;
		@(posedge clk) disable iff (!rst_b)
		cmdStrobe && cmdByte == CMD_READ_CH1 |=> rdData == result1;
	endproperty
	a_sel_ch1: assert property (p_sel_ch1)
		else $error("channel 1 select wrong");

	property p_hold_read;
		@(posedge clk) disable iff (!rst_b)
		running && !cmdStrobe && !doneNow |=> $stable(rdData);
	endproperty
	a_hold_read: assert property (p_hold_read)
		else $error("read data moved without cause");

	property p_ch0_stable;
		@(posedge clk) disable iff (!rst_b)
		running && !(doneNow && !curChan) |=> $stable(result0[6:0]);
	endproperty
	a_ch0_stable: assert property (p_ch0_stable)
		else $error("channel 0 changed without conversion");

	property p_alternate;
		@(posedge clk) disable iff (!rst_b)
		doneNow && running ##1 running |-> curChan != $past(curChan);
	endproperty
	a_alternate: assert property (p_alternate)
		else $error("channel did not alternate");

	property p_valid_set;
		@(posedge clk) disable iff (!rst_b)
		doneNow && curChan |=> result1 == {1'b1, $past(adcCode)};
	endproperty
	a_valid_set: assert property (p_valid_set)
		else $error("channel 1 result not stored valid");

	property p_no_valid_off;
		@(posedge clk) disable iff (!rst_b)
		!running ##1 !running |-> !result0[VALID_BIT] && !result1[VALID_BIT];
	endproperty
	a_no_valid_off: assert property (p_no_valid_off)
		else $error("valid set while powered down");

	property p_valid_ch0;
		@(posedge clk) disable iff (!rst_b)
		doneNow && !curChan |=> result0 == {1'b1, $past(adcCode)};
	endproperty
	a_valid_ch0: assert property (p_valid_ch0)
		else $error("channel 0 result not stored valid");

	property p_ch1_stable;
		@(posedge clk) disable iff (!rst_b)
		running && !(doneNow && curChan) |=> $stable(result1[6:0]);
	endproperty
	a_ch1_stable: assert property (p_ch1_stable)
		else $error("channel 1 changed without conversion");

	property p_sel_ch0;
		@(posedge clk) disable iff (!rst_b)
		cmdStrobe && cmdByte == CMD_READ_CH0 |=> rdData == result0;
	endproperty
	a_sel_ch0: assert property (p_sel_ch0)
		else $error("channel 0 select wrong");

	// Valid must survive reads and the other channel's conversion
	property p_valid_hold;
		@(posedge clk) disable iff (!rst_b)
		running && result0[VALID_BIT] |=> result0[VALID_BIT];
	endproperty
	a_valid_hold: assert property (p_valid_hold)
		else $error("channel 0 valid dropped while running");

	property p_restart;
		@(posedge clk) disable iff (!rst_b)
		!running |=> !curChan && integCnt == '0;
	endproperty
	a_restart: assert property (p_restart)
		else $error("sequencer did not restart at channel 0");

	property p_done_pulse;
		@(posedge clk) disable iff (!rst_b)
		doneNow |=> !doneNow;
	endproperty
	a_done_pulse: assert property (p_done_pulse)
		else $error("conversion done lasted more than one cycle");

	c_readback: cover property (@(posedge clk) disable iff (!rst_b)
		cmdStrobe && cmdByte == CMD_READ_CTRL);
	c_conv0: cover property (@(posedge clk) disable iff (!rst_b)
		doneNow && !curChan);
	c_conv1: cover property (@(posedge clk) disable iff (!rst_b)
		doneNow && curChan);
	c_power_down: cover property (@(posedge clk) disable iff (!rst_b)
		cmdStrobe && cmdByte == CMD_POWER_DOWN);
	c_sel_ch1: cover property (@(posedge clk) disable iff (!rst_b)
		cmdStrobe && cmdByte == CMD_READ_CH1);
endmodule : lsr_readout

`default_nettype wire

/* lsr_host_model.sv */
`timescale 1ns/10ps
`default_nettype none

// ------------------------------------------------------------------
// SMBus host: Send Byte and Receive Byte only
// ------------------------------------------------------------------
module lsr_host_model (
	input  wire logic clk,
	input  wire logic sda,
	output logic      scl,
	output logic      sdaLow
);
	initial begin
		scl = 1'b1;
		sdaLow = 1'b0;
	end

	// Half of the 80 ns link period
	task automatic hp;
		repeat (8) @(negedge clk);
	endtask : hp

	task automatic start;
		hp;
		sdaLow = 1'b1;
		hp;
		scl = 1'b0;
	endtask : start

	// Data moves well inside the low half, never on the clock edges
	task automatic xfer(input logic [7:0] w, output logic [7:0] r,
		output logic ack);
		logic s;
		for (int i = 8; i >= 0; i--) begin
			repeat (3) @(negedge clk);
			sdaLow = (i > 0) ? ~w[i-1] : 1'b0;
			repeat (5) @(negedge clk);
			scl = 1'b1;
			s = sda;
			hp;
			scl = 1'b0;
			if (i > 0)
				r[i-1] = s;
			else
				ack = ~s;
		end
	endtask : xfer

	task automatic stop;
		repeat (3) @(negedge clk);
		sdaLow = 1'b1;
		repeat (5) @(negedge clk);
		scl = 1'b1;
		hp;
		sdaLow = 1'b0;
		hp;
	endtask : stop

	task automatic sendByte(input logic [6:0] a, input logic [7:0] c,
		output logic ok);
		logic [7:0] r;
		logic a1;
		logic a2;
		start;
		xfer({a, 1'b0}, r, a1);
		xfer(c, r, a2);
		stop;
		ok = a1 & a2;
	endtask : sendByte

	// Host leaves the data line released for the final NACK
	task automatic recvByte(input logic [6:0] a, output logic [7:0] d,
		output logic ok);
		logic a2;
		start;
		xfer({a, 1'b1}, d, ok);
		xfer(8'hff, d, a2);
		stop;
	endtask : recvByte

	// Companded code to linear count; halving 33 keeps the truncation
	function automatic int decodeCount(input logic [6:0] code);
		int c;
		int s;
		c = int'(code[6:4]);
		s = int'(code[3:0]);
		return ((33 * ((1 << c) - 1)) >> 1) + (s << c);
	endfunction : decodeCount

	// A dark channel 0 would divide by zero
	function automatic real luxOf(input int ch0, input int ch1);
		real ratio;
		if (ch0 == 0)
			return 0.0;
		ratio = real'(ch1) / real'(ch0);
		return real'(ch0) * 0.46 * $exp(-3.13 * ratio);
	endfunction : luxOf
endmodule : lsr_host_model

`default_nettype wire

/* lsr_readout_tb.sv */
`timescale 1ns/10ps
`default_nettype none

// ------------------------------------------------------------------
// Readout bench
// ------------------------------------------------------------------
module lsr_readout_tb;
	import lsr_pkg::*;
	localparam int         INTEG = 2000;
	localparam logic [6:0] CODE0 = 7'h5a;
	localparam logic [6:0] CODE1 = 7'h25;
	logic       clk, rst_b, scl, hostLow, smbDataOut, smbDataOe, ok;
	logic       convChannel, convDone, converterEnable, powerOn;
	logic [6:0] adcCode;
	logic [7:0] rd, rd0, rd1;
	wire logic  sda;
	int         failures, cmp_count, cycleCount, gapCnt, lastGap;
	int         cnt0, cnt1, luxInt;

	// Pull-up: low while either side pulls
	assign sda = ~(hostLow | (smbDataOe & ~smbDataOut));

	lsr_readout #(.INTEG_CYCLES(INTEG)) u_lsr_readout (
		.clk(clk), .rst_b(rst_b), .smbClkIn(scl), .smbDataIn(sda),
		.smbDataOut(smbDataOut), .smbDataOe(smbDataOe),
		.adcCode(adcCode), .convChannel(convChannel),
		.convDone(convDone), .converterEnable(converterEnable),
		.powerOn(powerOn));

	lsr_host_model u_lsr_host_model (
		.clk(clk), .sda(sda), .scl(scl), .sdaLow(hostLow));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	always @(posedge clk) begin
		cycleCount <= cycleCount + 1;
		gapCnt <= (convDone === 1'b1) ? 1 : gapCnt + 1;
		if (convDone === 1'b1)
			lastGap <= gapCnt;
		if (cycleCount == 30000) begin
			failures++;
			complete_run;
		end
	end

	// Each channel sees its own fixed light level
	always @(negedge clk)
		adcCode <= convChannel ? CODE1 : CODE0;

	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : complete_run

	task automatic chk(string nm, logic [15:0] got, logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
			failures++;
		end
	endtask : chk

	task automatic snd(logic [7:0] c);
		u_lsr_host_model.sendByte(DEV_ADDR, c, ok);
		chk("send ack", {7'h0, ok}, 8'h01);
	endtask : snd

	task automatic rcv(string nm, logic [7:0] exp);
		u_lsr_host_model.recvByte(DEV_ADDR, rd, ok);
		chk(nm, rd, exp);
	endtask : rcv

	task automatic waitDone;
		int n;
		n = 0;
		while (convDone !== 1'b1 && n < 3 * INTEG) begin
			@(negedge clk);
			n++;
		end
		chk("done seen", {7'h0, convDone}, 8'h01);
		@(negedge clk);
	endtask : waitDone

	initial begin
		rst_b = 1'b0;
		repeat (12) @(negedge clk);
		rst_b = 1'b1;
		repeat (4) @(negedge clk);
		chk("reset enables", {6'h0, converterEnable, powerOn}, 8'h00);
		chk("data drive level", {7'h0, smbDataOut}, 8'h00);
		snd(CMD_READ_CTRL);
		rcv("control readback", CMD_READ_CTRL);
		snd(CMD_READ_CH0);
		chk("enables", {6'h0, converterEnable, powerOn}, 8'h03);
		rcv("ch0 before conversion", 8'h00);
		waitDone;
		chk("channel after ch0", {7'h0, convChannel}, 8'h01);
		rcv("ch0 first read", {1'b1, CODE0});
		rd0 = rd;
		rcv("ch0 repeat read", {1'b1, CODE0});
		snd(CMD_READ_CH1);
		rcv("ch1 before conversion", 8'h00);
		waitDone;
		chk("integration length", lastGap[7:0], INTEG[7:0]);
		chk("integration high", lastGap[15:8], INTEG[15:8]);
		rcv("ch1 result", {1'b1, CODE1});
		rd1 = rd;
		cnt0 = u_lsr_host_model.decodeCount(rd0[6:0]);
		cnt1 = u_lsr_host_model.decodeCount(rd1[6:0]);
		chk("ch0 count", cnt0[15:0], 16'h033f);
		chk("ch1 count", cnt1[15:0], 16'h0045);
		luxInt = $rtoi(u_lsr_host_model.luxOf(cnt0, cnt1));
		chk("lux", luxInt[15:0], 16'h0126);
		cnt0 = u_lsr_host_model.decodeCount(7'h00);
		luxInt = $rtoi(u_lsr_host_model.luxOf(cnt0, cnt1));
		chk("dark lux", luxInt[15:0], 16'h0000);
		snd(CMD_POWER_DOWN);
		chk("power down", {6'h0, converterEnable, powerOn}, 8'h00);
		chk("restart channel", {7'h0, convChannel}, 8'h00);
		snd(CMD_READ_CH0);
		rcv("ch0 after power down", {1'b0, CODE0});
		u_lsr_host_model.recvByte(~DEV_ADDR, rd, ok);
		chk("foreign address ack", {7'h0, ok}, 8'h00);
		complete_run;
	end
endmodule : lsr_readout_tb

`default_nettype wire
